// ---- hw/error_flag_and_interrupt_commands.sv ----
// Command interpreter for error flag clearing and interrupt control commands
//
// Contract
// - Code 36 type 0 clears all flags
// - Types 1 to 5 clear one flag each
// - Code 25 enables interrupt named by type
// - Number 255 enables interrupts globally
// - Code 26 disables interrupt named by type
// - Number 255 disables interrupts globally
// - Code 37 stores handler address for interrupt
// - Later vector definition overwrites earlier one
// - Code 38 restores saved context
// - Vector and return refused in direct mode
// - Executed direct commands reply with status 100
// - Reply frame: nine bytes, fixed order
`timescale 1ns/1ps
`default_nettype none

module error_flag_and_interrupt_commands
(
    // Clock and reset
    input  wire logic                             clock,
    input  wire logic                             srst,
    input  wire logic                             clk_en,
    // Addresses
    input  wire logic [7:0]                       module_address,
    input  wire logic [7:0]                       host_address,
    // Direct mode byte stream from host
    input  wire logic                             rx_valid,
    input  wire logic [7:0]                       rx_data,
    // Reply byte stream to host
    output var  logic                             tx_valid,
    output var  logic [7:0]                       tx_data,
    input  wire logic                             tx_ready,
    // Stored program commands
    input  wire logic                             prog_valid,
    input  wire cmd_pkg::command_t                prog_cmd,
    // Error flags
    input  wire logic [cmd_pkg::FLAG_COUNT-1:0]   flag_raise,
    output var  logic [cmd_pkg::FLAG_COUNT-1:0]   error_flags,
    // Interrupt control
    output var  logic [cmd_pkg::IRQ_COUNT-1:0]    irq_enable,
    output var  logic                             irq_global_enable,
    input  wire logic [7:0]                       vector_num,
    output var  logic [31:0]                      vector_addr,
    // Execution context
    input  wire logic                             context_save,
    input  wire cmd_pkg::context_t                context_in,
    output var  logic                             context_restore,
    output var  cmd_pkg::context_t                context_out
);
    import cmd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Frame receiver

    logic [3:0] rx_count;
    logic [3:0] next_rx_count;
    logic [7:0] rx_sum;
    logic [7:0] next_rx_sum;
    logic [7:0] rx_target;
    logic [7:0] next_rx_target;
    command_t   rx_cmd;
    command_t   next_rx_cmd;
    logic       pend;
    logic       next_pend;
    logic       pend_ok;
    logic       next_pend_ok;
    command_t   pend_cmd;
    command_t   next_pend_cmd;
    logic       take_direct;

    always_comb
    begin
        next_rx_count  = rx_count;
        next_rx_sum    = rx_sum;
        next_rx_target = rx_target;
        next_rx_cmd    = rx_cmd;
        next_pend      = pend && !take_direct;
        next_pend_ok   = pend_ok;
        next_pend_cmd  = pend_cmd;
        if (rx_valid)
        begin
            next_rx_count = rx_count + 4'h1;
            next_rx_sum   = rx_sum + rx_data;
            unique case (rx_count)
                IDX_TARGET: next_rx_target = rx_data;
                IDX_OPCODE: next_rx_cmd.opcode = rx_data;
                IDX_KIND:   next_rx_cmd.kind = rx_data;
                IDX_BANK:   next_rx_cmd.bank = rx_data;
                IDX_CHECKSUM:
                begin
                    next_rx_count = 4'h0;
                    next_rx_sum   = 8'h00;
                    // A frame for another module, or one arriving while one waits, is dropped
                    if (rx_target == module_address && !pend)
                    begin
                        next_pend     = 1'b1;
                        next_pend_cmd = rx_cmd;
                        next_pend_ok  = (rx_sum == rx_data);
                    end
                end
                default:    next_rx_cmd.value = {rx_cmd.value[23:0], rx_data};
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            rx_count  <= 4'h0;
            rx_sum    <= 8'h00;
            rx_target <= 8'h00;
            rx_cmd    <= '0;
            pend      <= 1'b0;
            pend_ok   <= 1'b0;
            pend_cmd  <= '0;
        end
        else if (clk_en)
        begin
            rx_count  <= next_rx_count;
            rx_sum    <= next_rx_sum;
            rx_target <= next_rx_target;
            rx_cmd    <= next_rx_cmd;
            pend      <= next_pend;
            pend_ok   <= next_pend_ok;
            pend_cmd  <= next_pend_cmd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode; stored program wins, a direct frame waits for an idle reply

    reply_state_t reply_state;
    command_t     exec_cmd;
    logic         known_op;
    logic         prog_only_op;
    logic         act;
    logic [7:0]   exec_status;

    always_comb
    begin
        take_direct  = pend && !prog_valid && reply_state == REPLY_IDLE;
        exec_cmd     = prog_valid ? prog_cmd : pend_cmd;
        prog_only_op = exec_cmd.opcode == OP_DEFINE_VEC || exec_cmd.opcode == OP_HANDLER_RET;
        known_op     = prog_only_op || exec_cmd.opcode == OP_CLEAR_FLAGS
                    || exec_cmd.opcode == OP_IRQ_ENABLE || exec_cmd.opcode == OP_IRQ_DISABLE;
        act          = prog_valid || (take_direct && pend_ok && known_op
                    && !prog_only_op);
        if (!pend_ok)
            exec_status = STATUS_BAD_SUM;
        else if (!known_op || prog_only_op)
            exec_status = STATUS_BAD_CMD;
        else
            exec_status = STATUS_OK;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Error flags and interrupt enables

    logic [FLAG_COUNT-1:0] next_error_flags;
    logic [IRQ_COUNT-1:0]  next_irq_enable;
    logic                  next_irq_global_enable;
    logic                  do_clear;
    logic                  do_enable;
    logic                  do_disable;

    assign do_clear   = act && exec_cmd.opcode == OP_CLEAR_FLAGS;
    assign do_enable  = act && exec_cmd.opcode == OP_IRQ_ENABLE;
    assign do_disable = act && exec_cmd.opcode == OP_IRQ_DISABLE;

    generate
        for (genvar f = 0; f < FLAG_COUNT; f++)
        begin : g_flag
            // A raise in the clearing cycle survives
            assign next_error_flags[f] = flag_raise[f] || (error_flags[f] && !(do_clear
                && (exec_cmd.kind == CLEAR_ALL
                ||  exec_cmd.kind == 8'(f + 1))));
        end
        for (genvar i = 0; i < IRQ_COUNT; i++)
        begin : g_irq
            assign next_irq_enable[i] = (do_enable && exec_cmd.kind == 8'(i))
                || (irq_enable[i] && !(do_disable && exec_cmd.kind == 8'(i)));
        end
    endgenerate

    always_comb
    begin
        next_irq_global_enable = irq_global_enable;
        if (do_enable && exec_cmd.kind == IRQ_GLOBAL)
            next_irq_global_enable = 1'b1;
        else if (do_disable && exec_cmd.kind == IRQ_GLOBAL)
            next_irq_global_enable = 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            error_flags       <= FLAGS_RESET;
            irq_enable        <= IRQ_EN_RESET;
            irq_global_enable <= GLOBAL_RESET;
        end
        else if (clk_en)
        begin
            error_flags       <= next_error_flags;
            irq_enable        <= next_irq_enable;
            irq_global_enable <= next_irq_global_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Handler vectors and saved context

    handler_vector_table u_vectors
    (
        .clock   (clock),
        .srst    (srst),
        .clk_en  (clk_en),
        .wr_en   (act && exec_cmd.opcode == OP_DEFINE_VEC),
        .wr_num  (exec_cmd.kind),
        .wr_addr (exec_cmd.value),
        .rd_num  (vector_num),
        .rd_addr (vector_addr)
    );

    context_t saved_context;
    context_t next_saved_context;
    logic     next_context_restore;
    context_t next_context_out;

    always_comb
    begin
        next_saved_context   = context_save ? context_in : saved_context;
        next_context_restore = act && exec_cmd.opcode == OP_HANDLER_RET;
        next_context_out     = next_context_restore ? saved_context : context_out;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            saved_context   <= '0;
            context_restore <= 1'b0;
            context_out     <= '0;
        end
        else if (clk_en)
        begin
            saved_context   <= next_saved_context;
            context_restore <= next_context_restore;
            context_out     <= next_context_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reply sender

    logic [3:0]   reply_idx;
    logic [3:0]   next_reply_idx;
    logic [7:0]   reply_status;
    logic [7:0]   next_reply_status;
    logic [7:0]   reply_opcode;
    logic [7:0]   next_reply_opcode;
    reply_state_t next_reply_state;
    logic         next_tx_valid;
    logic [7:0]   next_tx_data;

    // Value bytes are always zero, so the checksum needs only the header
    function automatic logic [7:0] reply_byte(input logic [3:0] idx, input logic [7:0] status,
                                              input logic [7:0] opcode);
        unique case (idx)
            4'h0:         reply_byte = host_address;
            4'h1:         reply_byte = module_address;
            4'h2:         reply_byte = status;
            4'h3:         reply_byte = opcode;
            IDX_CHECKSUM: reply_byte = host_address + module_address + status + opcode;
            default:      reply_byte = 8'h00;
        endcase
    endfunction : reply_byte

    always_comb
    begin
        next_reply_state  = reply_state;
        next_reply_idx    = reply_idx;
        next_reply_status = reply_status;
        next_reply_opcode = reply_opcode;
        next_tx_valid     = tx_valid;
        next_tx_data      = tx_data;
        unique case (reply_state)
            REPLY_IDLE:
                if (take_direct)
                begin
                    next_reply_state  = REPLY_SEND;
                    next_reply_idx    = 4'h0;
                    next_reply_status = exec_status;
                    next_reply_opcode = pend_cmd.opcode;
                    next_tx_valid     = 1'b1;
                    next_tx_data      = reply_byte(4'h0, exec_status, pend_cmd.opcode);
                end
            REPLY_SEND:
                if (tx_ready)
                begin
                    if (reply_idx == IDX_CHECKSUM)
                    begin
                        next_reply_state = REPLY_IDLE;
                        next_tx_valid    = 1'b0;
                    end
                    else
                    begin
                        next_reply_idx = reply_idx + 4'h1;
                        next_tx_data   = reply_byte(next_reply_idx, reply_status, reply_opcode);
                    end
                end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            reply_state  <= REPLY_IDLE;
            reply_idx    <= 4'h0;
            reply_status <= 8'h00;
            reply_opcode <= 8'h00;
            tx_valid     <= 1'b0;
            tx_data      <= 8'h00;
        end
        else if (clk_en)
        begin
            reply_state  <= next_reply_state;
            reply_idx    <= next_reply_idx;
            reply_status <= next_reply_status;
            reply_opcode <= next_reply_opcode;
            tx_valid     <= next_tx_valid;
            tx_data      <= next_tx_data;
        end
    end

endmodule : error_flag_and_interrupt_commands
`default_nettype wire

// ---- hw/cmd_pkg.sv ----
// Shared constants and types for the error flag and interrupt command block
package cmd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Frame layout
    localparam int         FRAME_BYTES   = 9;
    localparam logic [3:0] IDX_TARGET    = 4'h0;
    localparam logic [3:0] IDX_OPCODE    = 4'h1;
    localparam logic [3:0] IDX_KIND      = 4'h2;
    localparam logic [3:0] IDX_BANK      = 4'h3;
    localparam logic [3:0] IDX_VALUE_MSB = 4'h4;
    localparam logic [3:0] IDX_VALUE_LSB = 4'h7;
    localparam logic [3:0] IDX_CHECKSUM  = 4'h8;

    ////////////////////////////////////////////////////////////////////////////
    // Instruction codes of this group
    localparam logic [7:0] OP_IRQ_ENABLE  = 8'h19;
    localparam logic [7:0] OP_IRQ_DISABLE = 8'h1a;
    localparam logic [7:0] OP_CLEAR_FLAGS = 8'h24;
    localparam logic [7:0] OP_DEFINE_VEC  = 8'h25;
    localparam logic [7:0] OP_HANDLER_RET = 8'h26;

    // Type field values
    localparam logic [7:0] CLEAR_ALL      = 8'h00;
    localparam logic [7:0] CLEAR_LAST     = 8'h05;
    localparam logic [7:0] IRQ_GLOBAL     = 8'hff;

    // Reply status codes
    localparam logic [7:0] STATUS_OK      = 8'h64;
    localparam logic [7:0] STATUS_BAD_SUM = 8'h01;
    localparam logic [7:0] STATUS_BAD_CMD = 8'h02;

    ////////////////////////////////////////////////////////////////////////////
    // Error flags: bit n is cleared by type n+1
    localparam int         FLAG_COUNT     = 5;
    localparam int         FLAG_TIMEOUT   = 0;
    localparam int         FLAG_ALARM     = 1;
    localparam int         FLAG_DEVIATION = 2;
    localparam int         FLAG_POSITION  = 3;
    localparam int         FLAG_SHUTDOWN  = 4;
    localparam int         IRQ_COUNT      = 255;
    localparam int         VECTOR_DEPTH   = 256;

    // Values after reset
    localparam logic [FLAG_COUNT-1:0] FLAGS_RESET  = 5'h00;
    localparam logic [IRQ_COUNT-1:0]  IRQ_EN_RESET = '0;
    localparam logic                  GLOBAL_RESET = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic [7:0]  opcode;
        logic [7:0]  kind;
        logic [7:0]  bank;
        logic [31:0] value;
    } command_t;

    typedef struct packed {
        logic [31:0] accumulator;
        logic [31:0] x_register;
        logic [7:0]  flags;
        logic [15:0] program_counter;
    } context_t;

    typedef enum logic {REPLY_IDLE, REPLY_SEND} reply_state_t;

endpackage : cmd_pkg

// ---- hw/handler_vector_table.sv ----
// Handler entry point table, one word per interrupt number, registered read
`timescale 1ns/1ps
`default_nettype none

module handler_vector_table
(
    // Clock
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        clk_en,
    // Write port
    input  wire logic        wr_en,
    input  wire logic [7:0]  wr_num,
    input  wire logic [31:0] wr_addr,
    // Read port
    input  wire logic [7:0]  rd_num,
    output var  logic [31:0] rd_addr
);
    import cmd_pkg::*;

    logic [31:0] mem [VECTOR_DEPTH];

    // No reset on the array; undefined entries read as whatever was there
    always_ff @(posedge clock)
    begin
        if (clk_en && wr_en)
            mem[wr_num] <= wr_addr;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            rd_addr <= 32'h0000_0000;
        else if (clk_en)
            rd_addr <= mem[rd_num];
    end

endmodule : handler_vector_table
`default_nettype wire

// ---- tb/cmd_checker_assertions.sv ----
// Property checker for the command interpreter, bound to its ports
`timescale 1ns/1ps
`default_nettype none

module cmd_checker
(
    // Clock and reset
    input wire logic                           clock,
    input wire logic                           srst,
    input wire logic                           clk_en,
    // Reply stream
    input wire logic [7:0]                     host_address,
    input wire logic                           tx_valid,
    input wire logic [7:0]                     tx_data,
    input wire logic                           tx_ready,
    // Program port and state
    input wire logic                           prog_valid,
    input wire cmd_pkg::command_t              prog_cmd,
    input wire logic [cmd_pkg::FLAG_COUNT-1:0] flag_raise,
    input wire logic [cmd_pkg::FLAG_COUNT-1:0] error_flags,
    input wire logic [cmd_pkg::IRQ_COUNT-1:0]  irq_enable,
    input wire logic                           irq_global_enable,
    input wire logic [7:0]                     vector_num,
    input wire logic [31:0]                    vector_addr,
    input wire logic                           context_save,
    input wire cmd_pkg::context_t              context_in,
    input wire logic                           context_restore,
    input wire cmd_pkg::context_t              context_out
);
    import cmd_pkg::*;

    context_t saved;
    context_t next_saved;
    logic     saved_ok;
    logic     next_saved_ok;
    logic     go;
    logic     ret_go;

    assign go     = prog_valid && clk_en;
    assign ret_go = go && prog_cmd.opcode == OP_HANDLER_RET;

    // Shadow of the saved context; only trusted once a save was seen
    always_comb
    begin
        next_saved    = saved;
        next_saved_ok = saved_ok && !srst;
        if (context_save && clk_en)
        begin
            next_saved    = context_in;
            next_saved_ok = !srst;
        end
    end

    always_ff @(posedge clock)
    begin
        saved    <= next_saved;
        saved_ok <= next_saved_ok;
    end

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    chk_clear_all: assert property (go && prog_cmd.opcode == OP_CLEAR_FLAGS
        && prog_cmd.kind == CLEAR_ALL && flag_raise == '0 |=> error_flags == '0)
        else $error("clear all left a flag set");
    chk_clear_one: assert property (go && prog_cmd.opcode == OP_CLEAR_FLAGS
        && prog_cmd.kind inside {[8'h01:CLEAR_LAST]} && flag_raise == '0
        |=> error_flags == ($past(error_flags) & ~(5'h01 << ($past(prog_cmd.kind) - 8'h01))))
        else $error("single clear hit the wrong flags");
    chk_enable_one: assert property (go && prog_cmd.opcode == OP_IRQ_ENABLE
        && prog_cmd.kind != IRQ_GLOBAL |=> irq_enable[$past(prog_cmd.kind)])
        else $error("interrupt not enabled");
    chk_global_on: assert property (go && prog_cmd.opcode == OP_IRQ_ENABLE
        && prog_cmd.kind == IRQ_GLOBAL |=> irq_global_enable && $stable(irq_enable))
        else $error("global enable wrong");
    chk_disable_one: assert property (go && prog_cmd.opcode == OP_IRQ_DISABLE
        && prog_cmd.kind != IRQ_GLOBAL |=> !irq_enable[$past(prog_cmd.kind)])
        else $error("interrupt not disabled");
    chk_global_off: assert property (go && prog_cmd.opcode == OP_IRQ_DISABLE
        && prog_cmd.kind == IRQ_GLOBAL |=> !irq_global_enable && $stable(irq_enable))
        else $error("global disable wrong");
    chk_vector_read: assert property (go && prog_cmd.opcode == OP_DEFINE_VEC
        && prog_cmd.kind == vector_num ##1 clk_en && !prog_valid
        && vector_num == $past(prog_cmd.kind) |=> vector_addr == $past(prog_cmd.value, 2))
        else $error("vector entry not stored");
    chk_restore_ctx: assert property (ret_go && saved_ok
        |=> context_restore && context_out == $past(saved))
        else $error("context not restored");
    chk_restore_src: assert property (context_restore |-> $past(ret_go))
        else $error("restore without program return");
    chk_reply_head: assert property ($rose(tx_valid) |-> tx_data == host_address)
        else $error("reply does not start with host address");
    chk_reply_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte dropped before accept");
endmodule : cmd_checker

bind error_flag_and_interrupt_commands cmd_checker chk (.*);

`default_nettype wire

// ---- tb/host_model.sv ----
// Host side model: sends command frames, collects reply frames
`timescale 1ns/1ps
`default_nettype none

module host_model
(
    // Clock
    input  wire logic       clock,
    // Command bytes
    output var  logic       rx_valid,
    output var  logic [7:0] rx_data,
    // Reply bytes
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output var  logic       tx_ready
);
    int stall;

    initial
    begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        tx_ready = 1'b0;
        stall    = 0;
    end

    task automatic send_frame(input logic [7:0] tgt, op, kind,
                              input logic [31:0] value, input logic [7:0] flip);
        logic [7:0] f [9];
        f = '{tgt, op, kind, 8'h00, value[31:24], value[23:16], value[15:8],
              value[7:0], 8'h00};
        for (int i = 0; i < 8; i++)
            f[8] += f[i];
        f[8] ^= flip;
        for (int i = 0; i < 9; i++)
        begin
            @(posedge clock);
            #1 rx_valid = 1'b1;
            rx_data = f[i];
        end
        @(posedge clock);
        #1 rx_valid = 1'b0;
        // Released line must not keep showing the last byte
        rx_data = ~rx_data;
    endtask : send_frame

    task automatic get_reply(output logic [7:0] r [9], output logic ok);
        int n;
        ok = 1'b1;
        for (int i = 0; i < 9; i++)
        begin
            repeat (stall) @(posedge clock);
            #1 tx_ready = 1'b1;
            // Look between edges; the byte is taken at the next edge
            for (n = 0; tx_valid !== 1'b1 && n < 40; n++)
                @(posedge clock) #1;
            r[i] = tx_data;
            ok = ok && (n < 40);
            @(posedge clock);
            #1 tx_ready = 1'b0;
        end
    endtask : get_reply
endmodule : host_model

`default_nettype wire

// ---- tb/error_flag_and_interrupt_commands_bench.sv ----
// Self-checking bench for the command interpreter
`timescale 1ns/1ps
`default_nettype none

`define CHECK(what, exp, got) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
        begin \
            error_cnt++; \
            $display("wrong value %s expected %h seen %h", what, exp, got); \
        end \
    end

module error_flag_and_interrupt_commands_bench;
    import cmd_pkg::*;

    localparam logic [7:0] MOD  = 8'h01;
    localparam logic [7:0] HOST = 8'h02;

    logic                  clock;
    logic                  srst;
    logic                  clk_en;
    logic                  rx_valid;
    logic [7:0]            rx_data;
    logic                  tx_valid;
    logic [7:0]            tx_data;
    logic                  tx_ready;
    logic                  prog_valid;
    command_t              prog_cmd;
    logic [FLAG_COUNT-1:0] flag_raise;
    logic [FLAG_COUNT-1:0] error_flags;
    logic [IRQ_COUNT-1:0]  irq_enable;
    logic                  irq_global_enable;
    logic [7:0]            vector_num;
    logic [31:0]           vector_addr;
    logic                  context_save;
    context_t              context_in;
    logic                  context_restore;
    context_t              context_out;
    int                    error_cnt;
    int                    cmp_count;

    error_flag_and_interrupt_commands dut (
        .module_address(MOD), .host_address(HOST), .*
    );

    host_model host (.*);

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("comparisons %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    task automatic direct(input logic [7:0] op, kind, input logic [31:0] value,
                          input logic [7:0] status, flip);
        logic [7:0] r [9];
        logic [7:0] e [9];
        logic       ok;
        host.send_frame(MOD, op, kind, value, flip);
        host.get_reply(r, ok);
        // Value bytes are don't care, sent back as zero
        e = '{HOST, MOD, status, op, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 8; i++)
            e[8] += e[i];
        `CHECK("reply handshake", 1'b1, ok)
        for (int i = 0; i < 9; i++)
            `CHECK("reply byte", e[i], r[i])
    endtask : direct

    task automatic prog(input logic [7:0] op, kind, input logic [31:0] value);
        @(posedge clock);
        #1 prog_valid = 1'b1;
        prog_cmd = '{op, kind, 8'h00, value};
        @(posedge clock);
        #1 prog_valid = 1'b0;
    endtask : prog

    task automatic raise_all;
        @(posedge clock);
        #1 flag_raise = 5'h1f;
        @(posedge clock);
        #1 flag_raise = 5'h00;
    endtask : raise_all

    ////////////////////////////////////////////////////////////////
    initial
    begin
        logic [4:0] exp;
        srst = 1'b1;
        clk_en = 1'b1;
        prog_valid = 1'b0;
        prog_cmd = '0;
        flag_raise = 5'h00;
        vector_num = 8'h03;
        context_save = 1'b0;
        context_in = '{32'h11111111, 32'h22222222, 8'h33, 16'h4444};
        repeat (2) @(posedge clock);
        #1 srst = 1'b0;
        `CHECK("flags after reset", 5'h00, error_flags)
        raise_all();
        exp = 5'h1f;
        for (int k = 1; k <= 5; k++)
        begin
            direct(OP_CLEAR_FLAGS, 8'(k), 32'h0, STATUS_OK, 8'h00);
            exp[k-1] = 1'b0;
            `CHECK("one flag cleared", exp, error_flags)
        end
        raise_all();
        direct(OP_CLEAR_FLAGS, 8'h06, 32'h0, STATUS_OK, 8'h00);
        `CHECK("odd type clears none", 5'h1f, error_flags)
        direct(OP_CLEAR_FLAGS, CLEAR_ALL, 32'h0, STATUS_BAD_SUM, 8'h01);
        `CHECK("kept on bad sum", 5'h1f, error_flags)
        prog(OP_CLEAR_FLAGS, CLEAR_LAST, 32'h0);
        `CHECK("program clear one", 5'h0f, error_flags)
        clk_en = 1'b0;
        prog(OP_CLEAR_FLAGS, CLEAR_ALL, 32'h0);
        `CHECK("frozen flags", 5'h0f, error_flags)
        clk_en = 1'b1;
        direct(OP_CLEAR_FLAGS, CLEAR_ALL, 32'hdeadbeef, STATUS_OK, 8'h00);
        `CHECK("clear all", 5'h00, error_flags)
        // Enable, global on, disable, global off
        for (int i = 0; i < 4; i++)
        begin
            direct(i < 2 ? OP_IRQ_ENABLE : OP_IRQ_DISABLE, i[0] ? IRQ_GLOBAL : 8'hfe,
                   32'h0, STATUS_OK, 8'h00);
            `CHECK("single enable", i < 2, irq_enable[254])
            `CHECK("global enable", i == 1 || i == 2, irq_global_enable)
            prog(i < 2 ? OP_IRQ_ENABLE : OP_IRQ_DISABLE, i[0] ? IRQ_GLOBAL : 8'h03, 32'h0);
            `CHECK("program enable", i < 2, irq_enable[3])
        end
        prog(OP_DEFINE_VEC, 8'h03, 32'd50);
        @(posedge clock);
        #1 `CHECK("vector stored", 32'd50, vector_addr)
        prog(OP_DEFINE_VEC, 8'h03, 32'h00001234);
        @(posedge clock);
        #1 `CHECK("vector overwritten", 32'h00001234, vector_addr)
        direct(OP_DEFINE_VEC, 8'h03, 32'd7, STATUS_BAD_CMD, 8'h00);
        `CHECK("direct vector refused", 32'h00001234, vector_addr)
        @(posedge clock);
        #1 context_save = 1'b1;
        @(posedge clock);
        #1 context_save = 1'b0;
        direct(OP_HANDLER_RET, 8'hff, 32'h0, STATUS_BAD_CMD, 8'h00);
        `CHECK("direct return refused", 88'h0, context_out)
        prog(OP_HANDLER_RET, 8'hff, 32'h0);
        `CHECK("restore pulse", 1'b1, context_restore)
        `CHECK("restored context", 88'h1111111122222222334444, context_out)
        host.send_frame(8'h05, OP_CLEAR_FLAGS, CLEAR_ALL, 32'h0, 8'h00);
        repeat (12) @(posedge clock);
        `CHECK("foreign frame silent", 1'b0, tx_valid)
        // Slow host: reply bytes must wait for acceptance
        host.stall = 3;
        direct(OP_IRQ_ENABLE, 8'h05, 32'h0, STATUS_OK, 8'h00);
        report_and_stop();
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        report_and_stop();
    end
endmodule : error_flag_and_interrupt_commands_bench

`default_nettype wire
